// *** common/odg_pkg.sv ***
package odg_pkg;

  // ------------------------------------------------------------------
  // window and oversampling limits
  // ------------------------------------------------------------------
  localparam int          HIST_W       = 15;   // longest window
  localparam int          TALLY_W      = 4;    // holds 0..15
  localparam logic [3:0]  WIN_MIN      = 4'h1; // shortest window
  localparam logic [3:0]  WIN_MAX      = 4'hf; // longest window
  localparam logic [3:0]  WIN_DEFAULT  = 4'h5; // window after reset
  localparam int          OSR_MIN      = 5;    // least oversampling ratio
  localparam int          OSR_MAX      = 10;   // most oversampling ratio
  localparam logic [3:0]  OSR_DEFAULT  = 4'h8; // default ratio
  localparam int          CFG_W        = 4;    // selector switch bits
  localparam logic [3:0]  CFG_RESET    = 4'h0; // switch copy at reset

  // ------------------------------------------------------------------
  // one filtered sample travelling to the receiver
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       level;   // filtered data level
    logic [3:0] tally;   // ones in window when it was made
  } odg_word_t;

  // ------------------------------------------------------------------
  // capture state of the configuration switches
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ODG_CFG_WAIT = 2'b01,  // not yet latched since the last reset
    ODG_CFG_HELD = 2'b10   // latched, later changes ignored
  } odg_cfg_state_t;

endpackage : odg_pkg

// *** rtl/odg_deglitch.sv ***
// Behaviour
// - sample raw line at integer 5-10x rate
// - decide by counting ones, not sorting
// - update tally and history every sample
// - oldest bit set before shift: decrement tally
// - shift left, new one sets bit0, increments
// - window length selectable one to fifteen
// - output one when tally exceeds length/2
// - switches latched once after each reset
module odg_deglitch
  import odg_pkg::*;
#(
  parameter logic [3:0] OSR = odg_pkg::OSR_DEFAULT  // mclk per sample
)(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  raw_data,
  input  wire logic [3:0]            window_len,
  input  wire logic [3:0]            cfg_switch,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output odg_pkg::odg_word_t         out_word,
  output logic [3:0]                 cfg_latched,
  output logic                       cfg_done
);
  import odg_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // clamp the length into 1..15 so a zero never empties the window
  function automatic logic [3:0] clamp_len(input logic [3:0] len);
    clamp_len = (len < WIN_MIN) ? WIN_MIN : len;
  endfunction : clamp_len

  // mask that picks the sample about to leave the window
  function automatic logic [14:0] exit_mask(input logic [3:0] len);
    exit_mask = 15'h0001 << (len - 4'h1);
  endfunction : exit_mask

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic       raw_meta;   // first stage, read only by raw_sync
  logic       raw_sync;   // safe copy of the raw data line
  logic [3:0] cfg_meta;   // first stage of switch inputs
  logic [3:0] cfg_sync;   // safe copy of switch inputs

  // two flops per pin; the line is asynchronous to mclk
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      raw_meta <= 1'b0;
      raw_sync <= 1'b0;
      cfg_meta <= CFG_RESET;
      cfg_sync <= CFG_RESET;
    end
    else
    begin
      raw_meta <= raw_data;
      raw_sync <= raw_meta;
      cfg_meta <= cfg_switch;
      cfg_sync <= cfg_meta;
    end
  end

  // ------------------------------------------------------------------
  // sample rate divider
  // ------------------------------------------------------------------
  logic [3:0] div_cnt;       // counts mclk within one sample period
  logic [3:0] next_div_cnt;
  logic       sample_tick;   // one-cycle pulse per oversample
  logic       next_sample_tick;

  // fixed integer ratio; OSR picks 5..10 times the symbol rate
  always_comb
  begin
    next_div_cnt     = div_cnt + 4'h1;
    next_sample_tick = 1'b0;
    if (div_cnt >= OSR - 4'h1)
    begin
      next_div_cnt     = 4'h0;
      next_sample_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt     <= 4'h0;
      sample_tick <= 1'b0;
    end
    else
    begin
      div_cnt     <= next_div_cnt;
      sample_tick <= next_sample_tick;
    end
  end

  // ------------------------------------------------------------------
  // configuration capture
  // ------------------------------------------------------------------
  odg_cfg_state_t cfg_state;       // wait or held
  odg_cfg_state_t next_cfg_state;
  logic [3:0]     next_cfg_latched;

  // the switches are taken once, after the synchroniser has filled
  always_comb
  begin
    next_cfg_state   = cfg_state;
    next_cfg_latched = cfg_latched;
    case (cfg_state)
      ODG_CFG_WAIT:
      begin
        // wait for one sample tick so both sync stages hold pins
        if (sample_tick)
        begin
          next_cfg_latched = cfg_sync;
          next_cfg_state   = ODG_CFG_HELD;
        end
      end
      default:
      begin
        next_cfg_state = ODG_CFG_HELD;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cfg_state   <= ODG_CFG_WAIT;
      cfg_latched <= CFG_RESET;
      cfg_done    <= 1'b0;
    end
    else
    begin
      cfg_state   <= next_cfg_state;
      cfg_latched <= next_cfg_latched;
      cfg_done    <= (next_cfg_state == ODG_CFG_HELD);
    end
  end

  // ------------------------------------------------------------------
  // majority window
  // ------------------------------------------------------------------
  logic [14:0] sample_history;       // newest sample in bit 0
  logic [14:0] next_sample_history;
  logic [3:0]  ones_tally;           // ones inside the window
  logic [3:0]  next_ones_tally;
  logic [3:0]  win_len;              // clamped window length
  logic [14:0] window_exit_mask;     // marks the oldest sample
  logic        filt_level;           // filtered level
  logic        next_filt_level;
  logic        filt_strobe;          // new filtered word ready
  logic        next_filt_strobe;

  assign win_len          = clamp_len(window_len);
  assign window_exit_mask = exit_mask(win_len);

  // a running tally avoids a popcount; shrinking the window length
  // while running leaves the tally off until reset, as the dropped bits are never subtracted
  always_comb
  begin
    next_sample_history = sample_history;
    next_ones_tally     = ones_tally;
    next_filt_level     = filt_level;
    next_filt_strobe    = 1'b0;
    if (sample_tick)
    begin
      // oldest sample leaves the window
      if ((sample_history & window_exit_mask) != 15'h0000)
      begin
        next_ones_tally = next_ones_tally - 4'h1;
      end
      // bits beyond the window are dropped so they never return
      next_sample_history = (sample_history << 1)
                            & ((window_exit_mask << 1) - 15'h0001);
      if (raw_sync)
      begin
        next_sample_history[0] = 1'b1;
        next_ones_tally        = next_ones_tally + 4'h1;
      end
      // count of ones beats half the window: median is one
      next_filt_level  = (next_ones_tally > (win_len >> 1));
      next_filt_strobe = 1'b1;
    end
  end

  // asynchronous clear keeps history and tally aligned with the output
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sample_history <= 15'h0000;
      ones_tally     <= 4'h0;
      filt_level     <= 1'b0;
      filt_strobe    <= 1'b0;
    end
    else
    begin
      sample_history <= next_sample_history;
      ones_tally     <= next_ones_tally;
      filt_level     <= next_filt_level;
      filt_strobe    <= next_filt_strobe;
    end
  end

  // ------------------------------------------------------------------
  // two-entry output buffer
  // ------------------------------------------------------------------
  odg_word_t  buf_mem [2];       // storage slots
  odg_word_t  next_buf_mem [2];
  logic       wr_ptr;            // slot for next write
  logic       next_wr_ptr;
  logic       rd_ptr;            // slot for next read
  logic       next_rd_ptr;
  logic [1:0] fill;              // entries held
  logic [1:0] next_fill;
  logic       buf_ready;         // room for one more word
  logic       pop;               // receiver takes a word
  logic       push;              // filter delivers a word

  assign buf_ready = (fill != 2'h2);
  assign pop       = out_valid && out_ready;
  // a full buffer drops the word; at 5x oversampling the receiver
  // has five cycles per word so this only hits a stalled receiver
  assign push      = filt_strobe && (buf_ready || pop);

  always_comb
  begin
    next_buf_mem = buf_mem;
    next_wr_ptr  = wr_ptr;
    next_rd_ptr  = rd_ptr;
    next_fill    = fill;
    if (push)
    begin
      next_buf_mem[wr_ptr] = '{level: filt_level, tally: ones_tally};
      next_wr_ptr          = ~wr_ptr;
    end
    if (pop)
    begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop)
    begin
      next_fill = fill + 2'h1;
    end
    else if (pop && !push)
    begin
      next_fill = fill - 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      fill       <= 2'h0;
      out_valid  <= 1'b0;
      out_word   <= '0;
    end
    else
    begin
      buf_mem   <= next_buf_mem;
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      fill      <= next_fill;
      out_valid <= (next_fill != 2'h0);
      out_word  <= next_buf_mem[next_rd_ptr];
    end
  end

endmodule : odg_deglitch

// *** tb/odg_deglitch_properties.sv ***
module odg_deglitch_chk
  import odg_pkg::*;
(
  input wire logic               mclk,
  input wire logic               reset,
  input wire logic [3:0]         window_len,
  input wire logic               out_valid,
  input wire logic               out_ready,
  input wire odg_pkg::odg_word_t out_word,
  input wire logic [3:0]         cfg_latched,
  input wire logic               cfg_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] eff_len;  // zero length acts as one
  logic [3:0] prev_t;   // tally of the last accepted word
  logic       have_p;   // prev_t holds a real word
  logic       in_gap;   // a stall may have dropped words
  assign eff_len = (window_len == 4'h0) ? 4'h1 : window_len;
  // remember the previous accepted word
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prev_t <= 4'h0;
      have_p <= 1'b0;
      in_gap <= 1'b0;
    end
    else if (out_valid && !out_ready)
    begin
      // a full buffer drops words, so the next accepted tally need
      // not neighbour the last one; restart once the buffer empties
      have_p <= 1'b0;
      in_gap <= 1'b1;
    end
    else if (!out_valid)
    begin
      in_gap <= 1'b0;
    end
    else if (out_ready)
    begin
      prev_t <= out_word.tally;
      have_p <= !in_gap;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_level_vs_tally: assert property (out_valid |->
    out_word.level == (out_word.tally > (eff_len >> 1)))
    else $error("level does not follow tally");
  chk_tally_in_window: assert property (out_valid |->
    out_word.tally <= eff_len) else $error("tally above window");
  chk_tally_step: assert property (out_valid && out_ready && have_p |->
    out_word.tally <= prev_t + 5'h1 && prev_t <= out_word.tally + 5'h1)
    else $error("tally moved by more than one");
  chk_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_word)) else $error("word lost in stall");
  chk_cfg_frozen: assert property (cfg_done |=>
    cfg_done && $stable(cfg_latched)) else $error("switch copy moved");
  chk_cfg_soon: assert property ($fell(reset) |-> ##[1:16] cfg_done)
    else $error("switches not captured");
  chk_reset_clear: assert property ($fell(reset) |->
    !out_valid && out_word == '0 && !cfg_done) else $error("reset left data");
  chk_sample_soon: assert property ($fell(reset) |-> ##[1:16] out_valid)
    else $error("no sample after reset");
  cov_stall: cover property (out_valid && !out_ready);
  cov_high: cover property (out_valid && out_word.level);
  cov_full: cover property (out_valid && out_word.tally == 4'hf);
endmodule : odg_deglitch_chk
bind odg_deglitch odg_deglitch_chk u_chk (.mclk(mclk), .reset(reset),
  .window_len(window_len), .out_valid(out_valid), .out_ready(out_ready),
  .out_word(out_word), .cfg_latched(cfg_latched), .cfg_done(cfg_done));

// *** tb/odg_deglitch_tb.sv ***
module odg_deglitch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import odg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [3:0] OSR = 4'h5;  // short ratio keeps the run brief
  logic       mclk, reset, level, raw_data, out_ready, out_valid, cfg_done;
  logic [3:0] window_len, cfg_switch, cfg_latched;
  odg_word_t  out_word;
  odg_word_t  q[$];                   // accepted words, in order
  int         n_mismatch, checked;
  odg_radio_model u_radio (.mclk(mclk), .level(level), .raw_data(raw_data));
  odg_deglitch #(.OSR(OSR)) dut (.mclk(mclk), .reset(reset),
    .raw_data(raw_data), .window_len(window_len), .cfg_switch(cfg_switch),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .cfg_latched(cfg_latched), .cfg_done(cfg_done));
  always #4 mclk = ~mclk;
  // collect every word the receiver takes; the falling edge sees the
  // settled handshake that the next rising edge will act on
  always @(negedge mclk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_word);
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp_bit(input logic g, input logic e, input string m);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : cmp_bit
  task automatic cmp_nib(input logic [3:0] g, input logic [3:0] e,
                         input string m);
    cmp_bit(g === e, 1'b1, m);
  endtask : cmp_nib
  task automatic hold(input logic v, input int n);
    level <= v;
    repeat (n * OSR) @(posedge mclk);
  endtask : hold
  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // switch copy taken once, later moves ignored
  task automatic cfg_check(input logic [3:0] v);
    int i;
    for (i = 0; i < 40 && cfg_done !== 1'b1; i++) @(posedge mclk);
    if (i == 40)
    begin
      cmp_bit(1'b0, 1'b1, "cfg_done timeout");
      final_report();
    end
    cmp_nib(cfg_latched, v, "switch copy");
    cfg_switch <= ~v;
    hold(1'b0, 3);
    cmp_nib(cfg_latched, v, "switch copy after change");
  endtask : cfg_check
  // ones flood the window then drain out of it
  task automatic ramp(input logic [3:0] l);
    int i;
    window_len <= l;
    hold(1'b0, 20);
    q.delete();
    hold(1'b1, l + 4);
    for (i = 1; i < q.size(); i++)
    begin
      cmp_bit(q[i].tally - q[i-1].tally <= 1, 1'b1, "ramp step");
      cmp_bit(q[i].level, q[i].tally > (l >> 1), "ramp level");
    end
    cmp_nib(q[$].tally, l, "full tally");
    // one word per OSR clocks: the hold spans exactly l + 4 samples
    cmp_bit(q.size() == l + 4, 1'b1, "word rate");
    hold(1'b0, l + 4);
    cmp_nib(q[$].tally, 4'h0, "drained tally");
    cmp_bit(q[$].level, 1'b0, "drained level");
  endtask : ramp
  // short bursts in a window of five: three ones is the first pass
  task automatic glitch(input int w);
    logic [3:0] mx;
    logic       hi;
    mx = 4'h0;
    hi = 1'b0;
    window_len <= 4'h5;
    hold(1'b0, 8);
    q.delete();
    hold(1'b1, w);
    hold(1'b0, 8);
    foreach (q[i])
    begin
      if (q[i].tally > mx) mx = q[i].tally;
      hi |= q[i].level;
    end
    cmp_nib(mx, 4'(w), "burst tally");
    cmp_bit(hi, w > 2, "burst level");
  endtask : glitch
  // receiver stalls while ones pour in, nothing is taken
  task automatic stall();
    out_ready <= 1'b0;
    q.delete();
    hold(1'b1, 4);
    cmp_bit(out_valid, 1'b1, "valid in stall");
    cmp_bit(q.size() == 0, 1'b1, "pop in stall");
    out_ready <= 1'b1;
    hold(1'b0, 20);
    cmp_nib(q[$].tally, 4'h0, "after stall");
  endtask : stall
  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    level = 1'b0;
    window_len = 4'h5;
    cfg_switch = 4'ha;
    out_ready = 1'b1;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    cmp_bit(out_valid, 1'b0, "valid in reset");
    reset <= 1'b0;
    cfg_check(4'ha);
    ramp(4'h1);
    ramp(4'h5);
    ramp(4'hf);
    glitch(1);
    glitch(2);
    glitch(3);
    stall();
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp_bit(cfg_done, 1'b0, "cfg_done in reset");
    reset <= 1'b0;
    cfg_check(4'h5);
    final_report();
  end
endmodule : odg_deglitch_tb

// *** tb/odg_radio_model.sv ***
// ----------------------------------------
// radio raw data pin, push-pull, no glitches
// ----------------------------------------
module odg_radio_model (
  input  wire logic mclk,      // sample clock domain
  input  wire logic level,     // symbol level asked by the bench
  output logic      raw_data   // demodulated line to the filter
);
  timeunit 1ns;
  timeprecision 1ps;
  // one register so the pin changes a cycle after the request
  always_ff @(posedge mclk)
  begin
    raw_data <= level;
  end
endmodule : odg_radio_model
